//--- inc/output_driver_regs.svh
// register offsets, field positions and timing constants of the output driver
`ifndef OUTPUT_DRIVER_REGS_SVH
`define OUTPUT_DRIVER_REGS_SVH
`define FRAME_BITS        16
`define CRC_FRAME_BITS    24
`define POS_ADDR_HI       15
`define POS_ADDR_LO       13
`define POS_RW            12
`define POS_ZERO          11
`define POS_RANGE_HI      10
`define POS_RANGE_LO      7
`define POS_CLEAR_VALUE_SELECT        6
`define POS_OUTPUT_ENABLE_BIT         5
`define POS_SWCLEAR       4
`define POS_RSEL          3
`define POS_SWRESET       2
`define READ_ONE_BIT      1'h1
`define READ_ZERO_BIT     1'h0
`define CRC_POLY          8'h07
`define CTRL_RESET        8'h00
`define READ_FIRST_EDGE   5'h05
`endif

//--- inc/output_driver_pkg.sv
// types shared by the output driver files
package output_driver_pkg;
  typedef enum logic [3:0]
  {
    CFG_OFF    = 4'h0,
    CFG_CURENT = 4'h1,
    CFG_VOLT   = 4'h2,
    CFG_BAD    = 4'h4
  } out_kind_type;
  typedef struct packed
  {
    logic [3:0] rangeCode;
    logic       clearSel;
    logic       outEnable;
    logic       softClear;
    logic       senseSel;
  } ctrl_type;
endpackage

//--- inc/frame_if.sv
// frame capture results passed from the shifter to the register bank
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
  logic        frameDone;
  logic [23:0] frameBits;
  logic [4:0]  bitCount;
  logic        sclkRise;
  logic        syncHigh;
  modport shifter (output frameDone, frameBits, bitCount, sclkRise, syncHigh);
  modport bank (input frameDone, frameBits, bitCount, sclkRise, syncHigh);
endinterface
`default_nettype wire

//--- verilog/serial_frame_rx.sv
// serial frame receiver: synchronises the link pins and shifts in bits
`timescale 1ns/1ps
`default_nettype none
`include "output_driver_regs.svh"
module serial_frame_rx
  import output_driver_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic sclk,
  input  wire logic syncN,
  input  wire logic sdi,
  frame_if.shifter  fr
);
  logic [1:0]  sclkSync_ff;
  logic [1:0]  syncSync_ff;
  logic [1:0]  sdiSync_ff;
  logic        sclkLast_ff;
  logic        syncLast_ff;
  logic [23:0] shift_ff;
  logic [4:0]  count_ff;
  logic        done_ff;
  logic        sclkFall;
  logic        syncRise;

  // two-stage synchronisers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sclkSync_ff <= 2'h3;
      syncSync_ff <= 2'h3;
      sdiSync_ff  <= 2'h0;
      sclkLast_ff <= 1'h1;
      syncLast_ff <= 1'h1;
    end
    else
    begin
      sclkSync_ff <= {sclkSync_ff[0], sclk};
      syncSync_ff <= {syncSync_ff[0], syncN};
      sdiSync_ff  <= {sdiSync_ff[0], sdi};
      sclkLast_ff <= sclkSync_ff[1];
      syncLast_ff <= syncSync_ff[1];
    end
  end

  assign sclkFall = sclkLast_ff & ~sclkSync_ff[1];
  assign syncRise = ~syncLast_ff & syncSync_ff[1];

  // msb-first shift on falling sclk while sync low
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shift_ff <= 24'h000000;
      count_ff <= 5'h00;
      done_ff  <= 1'h0;
    end
    else
    begin
      done_ff <= syncRise;
      if (syncRise)
      begin
        count_ff <= count_ff;
      end
      else if (syncSync_ff[1])
      begin
        count_ff <= 5'h00;
      end
      else if (sclkFall)
      begin
        shift_ff <= {shift_ff[22:0], sdiSync_ff[1]};
        if (count_ff != 5'h1F)
        begin
          count_ff <= count_ff + 5'h01;
        end
      end
    end
  end

  assign fr.frameDone = done_ff;
  assign fr.frameBits = shift_ff;
  assign fr.bitCount  = count_ff;
  assign fr.sclkRise  = ~sclkLast_ff & sclkSync_ff[1];
  assign fr.syncHigh  = syncSync_ff[1];
endmodule
`default_nettype wire

//--- verilog/output_driver_range_ctrl_status.sv
// control and status bank of the voltage/current output driver
// What this block does
// - rsel 0 codes 0-2 external-resistor current ranges
// - voltage codes decode; 40/44 V only rsel 0
// - rsel 1 codes 0-2 internal-resistor current ranges
// - rsel 1 codes D-F current overranges
// - clear select picks zero or midscale target
// - outputs disabled unless output enable set
// - addressed frame with read bit starts readback
// - data out tristate; enabled, data from edge 5
// - sync rising edge returns data out tristate
// - one read word holds status and control
// - read word layout address,1,0,range,ctrl,flags
// - four read-only flags, writes cannot set
// - any flag drives shared fault output low, software mode only
// - failing crc-8 sets crc error flag
// - overtemperature indication sets its flag
// - open current and shorted voltage set flags
// - hardware mode decodes range pins; range select output from control word
// - hardware mode: three dedicated fault pins
// - 16-bit msb-first frames on falling sclk
// - writes and read requests act only when address matches straps
// - 24-bit frame crc checked at sync rise
// - status read clears crc flag; shared fault clears only if no other flag set
`timescale 1ns/1ps
`default_nettype none
`include "output_driver_regs.svh"
module output_driver_range_ctrl_status
  import output_driver_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       syncN,
  input  wire logic       sdi,
  output logic            sdoOut,
  output logic            sdoOe,
  input  wire logic [2:0] addrStrapPins,
  input  wire logic       hardwareModeStrap,
  input  wire logic [3:0] rangeCodePins,
  input  wire logic       senseSelPin,
  input  wire logic       outEnablePin,
  input  wire logic       overTempIn,
  input  wire logic       currentOpenIn,
  input  wire logic       voltageShortIn,
  output logic            faultOut,
  output logic            faultOe,
  output logic            currentFaultNOut,
  output logic            currentFaultNOe,
  output logic            voltageFaultNOut,
  output logic            voltageFaultNOe,
  output logic            tempFaultNOut,
  output logic            tempFaultNOe,
  output logic            currentOutEnable,
  output logic            voltageOutEnable,
  output logic            externalSenseSel,
  output logic            overrangeSel,
  output logic [3:0]      rangeSelOut,
  output logic            clearActive,
  output logic            clearToMidscale,
  output logic            configIllegal
);
  frame_if fr ();

  serial_frame_rx rx
  (
    .clock (clock),
    .rst   (rst),
    .sclk  (sclk),
    .syncN (syncN),
    .sdi   (sdi),
    .fr    (fr)
  );

  logic [2:0]   strapSync0_ff;
  logic [2:0]   strapSync_ff;
  logic [8:0]   pinSync0_ff;
  logic [8:0]   pinSync_ff;
  logic [2:0]   faultSync0_ff;
  logic [2:0]   faultSync_ff;
  logic         hwMode_ff;
  ctrl_type     ctrl_ff;
  logic         crcErr_ff;
  logic         reading_ff;
  logic [15:0]  readWord_ff;
  logic         sdo_ff;
  logic [3:0]   kind_ff;
  logic         ovr_ff;
  logic         ext_ff;
  logic [15:0]  word;
  logic         addrOk;
  logic         crcOk;
  logic         is24;
  logic         is16;
  logic         frameOk;
  logic         frameRead;
  ctrl_type     active;
  out_kind_type kind;
  logic [3:0]   flags;

  // crc-8 over a bit string, polynomial x8+x2+x+1
  function automatic logic [7:0] crc8(input logic [15:0] data);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
    begin
      c = {c[6:0], 1'h0} ^ ((c[7] ^ data[i]) ? `CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // range decode to output kind
  function automatic out_kind_type decodeKind(input logic rs, input logic [3:0] rc);
    unique case (rc)
      4'h0, 4'h1, 4'h2: decodeKind = CFG_CURENT;
      4'h5, 4'h6, 4'h9, 4'hA: decodeKind = CFG_VOLT;
      4'hE, 4'hF: decodeKind = rs ? CFG_CURENT : CFG_VOLT;
      4'hD: decodeKind = rs ? CFG_CURENT : CFG_BAD;
      default: decodeKind = CFG_BAD;
    endcase
  endfunction

  // pin synchronisers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      strapSync0_ff <= 3'h0;
      strapSync_ff  <= 3'h0;
      pinSync0_ff   <= 9'h000;
      pinSync_ff    <= 9'h000;
      faultSync0_ff <= 3'h0;
      faultSync_ff  <= 3'h0;
    end
    else
    begin
      strapSync0_ff <= addrStrapPins;
      strapSync_ff  <= strapSync0_ff;
      pinSync0_ff   <= {hardwareModeStrap, rangeCodePins, senseSelPin, outEnablePin, 2'h0};
      pinSync_ff    <= pinSync0_ff;
      faultSync0_ff <= {overTempIn, currentOpenIn, voltageShortIn};
      faultSync_ff  <= faultSync0_ff;
    end
  end

  // strap level followed on every clock once reset is released
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hwMode_ff <= 1'h0;
    end
    else
    begin
      hwMode_ff <= pinSync_ff[8];
    end
  end

  assign word   = fr.frameBits[15:0];
  assign is16   = (fr.bitCount == 5'h10);
  assign is24   = (fr.bitCount == 5'h18);
  assign crcOk  = crc8(fr.frameBits[23:8]) == fr.frameBits[7:0];
  assign addrOk = is24 ? (fr.frameBits[23:21] == strapSync_ff) : (word[15:13] == strapSync_ff);

  // frame accepted: legal length, own address, software mode, crc good
  assign frameOk   = fr.frameDone && !hwMode_ff && addrOk && (is16 || (is24 && crcOk));
  assign frameRead = is24 ? fr.frameBits[8 + `POS_RW] : word[`POS_RW];

  // control register writes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_ff <= `CTRL_RESET;
    end
    else if (frameOk && !frameRead)
    begin
      if (is24 ? fr.frameBits[8 + `POS_SWRESET] : word[`POS_SWRESET])
      begin
        ctrl_ff <= `CTRL_RESET;
      end
      else if (is24)
      begin
        ctrl_ff <= fr.frameBits[`POS_RANGE_HI + 8:`POS_RSEL + 8];
      end
      else
      begin
        ctrl_ff <= word[`POS_RANGE_HI:`POS_RSEL];
      end
    end
  end

  // crc error flag, set wins over read clear
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      crcErr_ff <= 1'h0;
    end
    else if (fr.frameDone && is24 && !crcOk && !hwMode_ff)
    begin
      crcErr_ff <= 1'h1;
    end
    else if (fr.frameDone && reading_ff)
    begin
      crcErr_ff <= 1'h0;
    end
  end

  assign flags = {crcErr_ff, faultSync_ff};

  // readback armed by a read frame, ended by the following frame
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reading_ff <= 1'h0;
    end
    else if (fr.frameDone && reading_ff)
    begin
      reading_ff <= 1'h0;
    end
    else if (frameOk && frameRead)
    begin
      reading_ff <= 1'h1;
    end
  end

  // read word latched at read frame, shifted on rising sclk
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      readWord_ff <= 16'h0000;
      sdo_ff      <= 1'h0;
    end
    else if (frameOk && frameRead && !reading_ff)
    begin
      readWord_ff <= {strapSync_ff, `READ_ONE_BIT, `READ_ZERO_BIT, ctrl_ff.rangeCode,
                      ctrl_ff.clearSel, ctrl_ff.outEnable, ctrl_ff.senseSel, flags};
    end
    else if (reading_ff && !fr.syncHigh && fr.sclkRise && fr.bitCount >= `READ_FIRST_EDGE)
    begin
      sdo_ff      <= readWord_ff[15];
      readWord_ff <= {readWord_ff[14:0], 1'h0};
    end
  end

  assign sdoOut = sdo_ff;
  assign sdoOe  = reading_ff && !fr.syncHigh;

  // active configuration from pins or control word
  always_comb
  begin
    active = ctrl_ff;
    if (hwMode_ff)
    begin
      active.rangeCode = pinSync_ff[7:4];
      active.senseSel  = pinSync_ff[3];
      active.outEnable = pinSync_ff[2];
      active.softClear = 1'h0;
      active.clearSel  = 1'h0;
    end
  end

  assign kind = decodeKind(active.senseSel, active.rangeCode);

  // registered output configuration
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      kind_ff <= CFG_OFF;
      ovr_ff  <= 1'h0;
      ext_ff  <= 1'h0;
    end
    else
    begin
      kind_ff <= active.outEnable ? kind : CFG_OFF;
      ovr_ff  <= active.rangeCode[3];
      ext_ff  <= !active.senseSel && kind == CFG_CURENT;
    end
  end

  assign currentOutEnable = kind_ff == CFG_CURENT;
  assign voltageOutEnable = kind_ff == CFG_VOLT;
  assign configIllegal    = kind_ff == CFG_BAD;
  assign externalSenseSel = ext_ff;
  assign overrangeSel     = ovr_ff;
  assign rangeSelOut      = ctrl_ff.rangeCode;
  assign clearActive      = ctrl_ff.softClear && !hwMode_ff;
  assign clearToMidscale  = ctrl_ff.clearSel;

  // fault pins, open drain, low when driven
  assign faultOut         = 1'h0;
  assign faultOe          = !hwMode_ff && (|flags);
  assign currentFaultNOut = 1'h0;
  assign currentFaultNOe  = hwMode_ff && faultSync_ff[1];
  assign voltageFaultNOut = 1'h0;
  assign voltageFaultNOe  = hwMode_ff && faultSync_ff[0];
  assign tempFaultNOut    = 1'h0;
  assign tempFaultNOe     = hwMode_ff && faultSync_ff[2];
endmodule
`default_nettype wire

//--- verif/output_driver_monitor.sv
// port assertions of the output driver control and status bank
`timescale 1ns/1ps
`default_nettype none
module output_driver_monitor
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       syncN,
  input wire logic       sdoOe,
  input wire logic       hardwareModeStrap,
  input wire logic [3:0] rangeCodePins,
  input wire logic       senseSelPin,
  input wire logic       outEnablePin,
  input wire logic       overTempIn,
  input wire logic       currentOpenIn,
  input wire logic       voltageShortIn,
  input wire logic       faultOut,
  input wire logic       faultOe,
  input wire logic       voltageFaultNOe,
  input wire logic       currentOutEnable,
  input wire logic       voltageOutEnable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_sdo_idle: assert property (syncN [*6] |-> !sdoOe) else $error("sdo driven outside frame");
  a_temp_fault: assert property ((!hardwareModeStrap && overTempIn) [*6] |-> faultOe)
    else $error("hot core without fault");
  a_open_fault: assert property ((!hardwareModeStrap && currentOpenIn) [*6] |-> faultOe)
    else $error("open output without fault");
  a_hw_short: assert property ((hardwareModeStrap && voltageShortIn) [*6] |-> voltageFaultNOe)
    else $error("short without its pin");
  a_hw_no_shared: assert property (hardwareModeStrap [*6] |-> !faultOe) else $error("shared fault in hw");
  a_hw_gate: assert property ((hardwareModeStrap && !outEnablePin) [*6] |-> !currentOutEnable && !voltageOutEnable)
    else $error("output on while disabled");
  a_hw_range: assert property ((hardwareModeStrap && outEnablePin && !senseSelPin && rangeCodePins == 4'h5) [*8]
    |-> voltageOutEnable && !currentOutEnable) else $error("pin range not decoded");
  a_one_output: assert property (!(currentOutEnable && voltageOutEnable)) else $error("both outputs on");
  a_drain_low: assert property (faultOut == 1'b0) else $error("fault pin driven high");
  c_read: cover property (sdoOe);
  c_fault: cover property (faultOe);
  c_hw_short: cover property (hardwareModeStrap && voltageFaultNOe);
endmodule
bind output_driver_range_ctrl_status output_driver_monitor i_mon
(
  .clock             (clock),
  .rst               (rst),
  .syncN             (syncN),
  .sdoOe             (sdoOe),
  .hardwareModeStrap (hardwareModeStrap),
  .rangeCodePins     (rangeCodePins),
  .senseSelPin       (senseSelPin),
  .outEnablePin      (outEnablePin),
  .overTempIn        (overTempIn),
  .currentOpenIn     (currentOpenIn),
  .voltageShortIn    (voltageShortIn),
  .faultOut          (faultOut),
  .faultOe           (faultOe),
  .voltageFaultNOe   (voltageFaultNOe),
  .currentOutEnable  (currentOutEnable),
  .voltageOutEnable  (voltageOutEnable)
);
`default_nettype wire

//--- verif/host_model.sv
// host side of the serial link: sends frames and collects read data
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input  wire logic        clock,
  input  wire logic        sdo,
  output logic             sclk,
  output logic             syncN,
  output logic             sdi,
  output logic [19:0]      rdWord,
  output logic             rdStrobe
);
  initial
  begin
    sclk = 1'b1;
    syncN = 1'b1;
    sdi = 1'b0;
    rdWord = 20'h00000;
    rdStrobe = 1'b0;
  end
  // n bits, 160 ns clock, still and high between frames
  task automatic frame(input logic [23:0] bits, input int n, input logic grab);
    repeat (16) @(negedge clock);
    syncN = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = bits[i];
      repeat (8) @(negedge clock);
      sclk = 1'b0;
      repeat (16) @(negedge clock);
      sclk = 1'b1;
      repeat (8) @(negedge clock);
      rdWord = {rdWord[18:0], sdo};
    end
    repeat (8) @(negedge clock);
    syncN = 1'b1;
    sdi = ~sdi;
    rdStrobe = grab;
    @(negedge clock);
    rdStrobe = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench of the output driver control and status bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [2:0] ADDR = 3'h5;
  logic        clock, rst, sclk, syncN, sdi, sdoOut, sdoOe, sdoLine, flip, rdStrobe;
  logic        hardwareModeStrap, senseSelPin, outEnablePin, overTempIn, currentOpenIn, voltageShortIn;
  logic        faultOut, faultOe, currentFaultNOut, currentFaultNOe, voltageFaultNOut, voltageFaultNOe;
  logic        tempFaultNOut, tempFaultNOe, currentOutEnable, voltageOutEnable, externalSenseSel;
  logic        overrangeSel, clearActive, clearToMidscale, configIllegal;
  logic [2:0]  addrStrapPins;
  logic [3:0]  rangeCodePins, rangeSelOut;
  logic [19:0] rdWord;
  logic [15:0] lfsr, w, expQ[$];
  int          n_errors, num_checks;
  output_driver_range_ctrl_status i_dut
  (
    .clock             (clock),
    .rst               (rst),
    .sclk              (sclk),
    .syncN             (syncN),
    .sdi               (sdi),
    .sdoOut            (sdoOut),
    .sdoOe             (sdoOe),
    .addrStrapPins     (addrStrapPins),
    .hardwareModeStrap (hardwareModeStrap),
    .rangeCodePins     (rangeCodePins),
    .senseSelPin       (senseSelPin),
    .outEnablePin      (outEnablePin),
    .overTempIn        (overTempIn),
    .currentOpenIn     (currentOpenIn),
    .voltageShortIn    (voltageShortIn),
    .faultOut          (faultOut),
    .faultOe           (faultOe),
    .currentFaultNOut  (currentFaultNOut),
    .currentFaultNOe   (currentFaultNOe),
    .voltageFaultNOut  (voltageFaultNOut),
    .voltageFaultNOe   (voltageFaultNOe),
    .tempFaultNOut     (tempFaultNOut),
    .tempFaultNOe      (tempFaultNOe),
    .currentOutEnable  (currentOutEnable),
    .voltageOutEnable  (voltageOutEnable),
    .externalSenseSel  (externalSenseSel),
    .overrangeSel      (overrangeSel),
    .rangeSelOut       (rangeSelOut),
    .clearActive       (clearActive),
    .clearToMidscale   (clearToMidscale),
    .configIllegal     (configIllegal)
  );
  host_model i_host (.clock, .sdo(sdoLine), .sclk, .syncN, .sdi, .rdWord, .rdStrobe);
  assign sdoLine = sdoOe ? sdoOut : flip;
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) flip <= ~flip;
  always @(posedge clock)
    if (rdStrobe === 1'b1)
      check(rdWord[15:0], expQ.pop_front());
  initial
  begin
    #450000;
    n_errors++;
    summarize();
  end
  function automatic logic [15:0] nextRand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // bit 1 current, bit 0 voltage, zero for unused codes
  function automatic logic [1:0] kindOf(input logic rs, input logic [3:0] r);
    if (r inside {4'h0, 4'h1, 4'h2} || (rs && r inside {4'hD, 4'hE, 4'hF}))
      return 2'h2;
    if (r inside {4'h5, 4'h6, 4'h9, 4'hA} || (!rs && r inside {4'hE, 4'hF}))
      return 2'h1;
    return 2'h0;
  endfunction
  // b holds clear select, enable, clear, sense select
  function automatic logic [15:0] ctl(input logic [2:0] a, input logic [3:0] r, input logic [3:0] b);
    return {a, 2'b00, r, b, 3'b000};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] v);
    i_host.frame({8'h00, v}, 16, 1'b0);
    idle(12);
  endtask
  task automatic rd(input logic [15:0] exp);
    expQ.push_back(exp);
    i_host.frame({8'h00, ADDR, 1'b1, 12'h000}, 16, 1'b0);
    i_host.frame(24'h000000, 20, 1'b1);
    idle(12);
    check(sdoOe, 1'b0);
  endtask
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    logic [1:0] kd;
    n_errors = 0;
    num_checks = 0;
    flip = 1'b0;
    rst = 1'b1;
    addrStrapPins = ADDR;
    {hardwareModeStrap, senseSelPin, outEnablePin, rangeCodePins} = 7'h00;
    {overTempIn, currentOpenIn, voltageShortIn} = 3'h0;
    lfsr = 16'hD766;
    idle(2);
    rst = 1'b0;
    idle(8);
    for (int k = 0; k < 32; k++)
    begin
      kd = kindOf(k[4], k[3:0]);
      if (kd != 2'h0)
      begin
        lfsr = nextRand(lfsr);
        {overTempIn, currentOpenIn, voltageShortIn} = lfsr[2:0];
        wr(ctl(ADDR, k[3:0], {lfsr[3], 1'b1, lfsr[4], k[4]}));
        check(currentOutEnable, kd[1]);
        check(voltageOutEnable, kd[0]);
        check(rangeSelOut, k[3:0]);
        check(clearToMidscale, lfsr[3]);
        check(clearActive, lfsr[4]);
        check(faultOe, |lfsr[2:0]);
        check(externalSenseSel, kd[1] && !k[4]);
        check(overrangeSel, k[3]);
        check(configIllegal, 1'b0);
        rd({ADDR, 2'b10, k[3:0], lfsr[3], 1'b1, k[4], 1'b0, lfsr[2:0]});
      end
    end
    {overTempIn, currentOpenIn, voltageShortIn} = 3'h0;
    wr(ctl(ADDR, 4'h6, 4'h4));
    wr(ctl(3'h2, 4'h0, 4'h0));
    check(voltageOutEnable, 1'b1);
    wr(ctl(ADDR, 4'h6, 4'h0));
    check(voltageOutEnable, 1'b0);
    w = ctl(ADDR, 4'h1, 4'h4);
    i_host.frame({w, ~crc8(w)}, 24, 1'b0);
    idle(12);
    check(faultOe, 1'b1);
    rd({ADDR, 2'b10, 4'h6, 3'b000, 4'h8});
    check(faultOe, 1'b0);
    rd({ADDR, 2'b10, 4'h6, 3'b000, 4'h0});
    i_host.frame({w, crc8(w)}, 24, 1'b0);
    idle(12);
    check(currentOutEnable, 1'b1);
    wr(ctl(ADDR, 4'h1, 4'h4) | 16'h0004);
    check(currentOutEnable, 1'b0);
    rd({ADDR, 2'b10, 4'h0, 3'b000, 4'h0});
    rst = 1'b1;
    hardwareModeStrap = 1'b1;
    outEnablePin = 1'b1;
    rangeCodePins = 4'h5;
    idle(2);
    rst = 1'b0;
    idle(16);
    check(voltageOutEnable, 1'b1);
    {senseSelPin, rangeCodePins} = 5'h1D;
    {overTempIn, currentOpenIn, voltageShortIn} = 3'h7;
    idle(12);
    check(currentOutEnable, 1'b1);
    check(voltageFaultNOe, 1'b1);
    check(currentFaultNOe, 1'b1);
    check(tempFaultNOe, 1'b1);
    check({faultOut, currentFaultNOut, voltageFaultNOut, tempFaultNOut}, 4'h0);
    check(faultOe, 1'b0);
    outEnablePin = 1'b0;
    idle(12);
    check(currentOutEnable, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
